// ===== src/pns_pkg.sv
// package for the position number start handshake block
package pns_pkg;
  localparam int PNS_POS_W_MAX = 9;
  localparam logic [1:0] PNS_PAT_RESET = 2'h0;
  localparam int PNS_SETUP_MS = 6;
  localparam int PNS_CLK_MHZ = 100;
  localparam int PNS_SETUP_CYC = PNS_SETUP_MS * 1000 * PNS_CLK_MHZ;
  localparam int PNS_DIST_W = 24;
  localparam logic [PNS_POS_W_MAX-1:0] PNS_POS_RESET = 9'h000;
  localparam logic [15:0] PNS_ADDR_CTRL = 16'h0000;
  localparam logic [15:0] PNS_ADDR_WIDTH = 16'h0004;
  localparam logic [15:0] PNS_ADDR_STAT = 16'h0008;
  localparam logic [15:0] PNS_ADDR_CPOS = 16'h000c;
  localparam logic [31:0] PNS_WIDTH_RESET = 32'h0000_0010;
  localparam logic [1:0] PNS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PNS_RESP_SLVERR = 2'h2;
  localparam int PNS_CTRL_PAT_LSB = 0;
  localparam int PNS_CTRL_INP_BIT = 2;
  localparam int PNS_CTRL_SERVO_BIT = 3;
  typedef enum logic [2:0] {
    PNS_IDLE = 3'b000,
    PNS_HOME = 3'b001,
    PNS_MOVE = 3'b010,
    PNS_DONE = 3'b011
  } pns_state_t;
endpackage : pns_pkg

// ===== src/pns_axil_regs.sv
// axi4-lite register slave for the position handshake block
`timescale 1ns/100ps
module pns_axil_regs
  import pns_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [15:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] stat_in,
  input wire logic [31:0] cpos_in,
  output logic [31:0] ctrl,
  output logic [31:0] pos_width
);
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [15:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, ctrl_q, ctrl_d, wid_q, wid_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] merged;

  assign s_awready = !aw_q && !b_q;
  assign s_wready = !w_q && !b_q;
  assign s_bvalid = b_q;
  assign s_bresp = br_q;
  assign s_arready = !r_q;
  assign s_rvalid = r_q;
  assign s_rdata = rd_q;
  assign s_rresp = rr_q;
  assign ctrl = ctrl_q;
  assign pos_width = wid_q;

  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    r_d = r_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    br_d = br_q;
    rr_d = rr_q;
    rd_d = rd_q;
    ctrl_d = ctrl_q;
    wid_d = wid_q;
    merged = 32'h0000_0000;
    if (s_awvalid && s_awready)
    begin
      aw_d = 1'b1;
      awa_d = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      w_d = 1'b1;
      wd_d = s_wdata;
      ws_d = s_wstrb;
    end
    if (aw_q && w_q)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      br_d = PNS_RESP_OKAY;
      for (int i = 0; i < 4; i++)
      begin
        merged[i*8 +: 8] = ws_q[i] ? wd_q[i*8 +: 8] : (awa_q == PNS_ADDR_CTRL ? ctrl_q[i*8 +: 8] : wid_q[i*8 +: 8]);
      end
      if (awa_q == PNS_ADDR_CTRL)
        ctrl_d = merged;
      else if (awa_q == PNS_ADDR_WIDTH)
        wid_d = merged;
      else if (awa_q != PNS_ADDR_STAT && awa_q != PNS_ADDR_CPOS)
        br_d = PNS_RESP_SLVERR;
    end
    if (b_q && s_bready)
      b_d = 1'b0;
    if (s_arvalid && s_arready)
    begin
      r_d = 1'b1;
      rr_d = PNS_RESP_OKAY;
      unique case (s_araddr)
        PNS_ADDR_CTRL: rd_d = ctrl_q;
        PNS_ADDR_WIDTH: rd_d = wid_q;
        PNS_ADDR_STAT: rd_d = stat_in;
        PNS_ADDR_CPOS: rd_d = cpos_in;
        default:
        begin
          rd_d = 32'h0000_0000;
          rr_d = PNS_RESP_SLVERR;
        end
      endcase
    end
    else if (r_q && s_rready)
      r_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awa_q <= 16'h0000;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      br_q <= PNS_RESP_OKAY;
      rr_q <= PNS_RESP_OKAY;
      rd_q <= 32'h0000_0000;
      ctrl_q <= 32'h0000_0000;
      wid_q <= PNS_WIDTH_RESET;
    end
    else
    begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      ctrl_q <= ctrl_d;
      wid_q <= wid_d;
    end
  end
endmodule : pns_axil_regs

// ===== src/pns_top.sv
// position number start handshake: sequencer, outputs and register slave
`timescale 1ns/100ps
module pns_top
  import pns_pkg::*;
#(
  parameter int POS_W = PNS_POS_W_MAX,
  parameter int DIST_W = PNS_DIST_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [POS_W-1:0] cmd_position_number,
  input wire logic start_request,
  output logic [POS_W-1:0] completed_position_number,
  output logic positioning_complete,
  output logic motion_active,
  output logic home_return_done,
  output logic move_launch,
  output logic [POS_W-1:0] move_target,
  output logic home_launch,
  input wire logic home_finished,
  input wire logic [DIST_W-1:0] remaining_distance,
  input wire logic motion_pending,
  input wire logic [15:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [15:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  pns_state_t st_q, st_d;
  logic [31:0] ctrl, pos_width, stat_w, cpos_w;
  logic [1:0] pattern;
  logic inp_mode, servo_on, in_width;
  logic start_q, start_rise;
  logic home_q, home_d, positioning_complete_q, positioning_complete_d, move_q, move_d, launch_q, launch_d, hl_q, hl_d;
  logic [POS_W-1:0] tgt_q, tgt_d, cpos_q, cpos_d, last_q, last_d, pmask;
  logic [POS_W-1:0] out_pos;

  assign pattern = ctrl[PNS_CTRL_PAT_LSB +: 2];
  assign inp_mode = ctrl[PNS_CTRL_INP_BIT];
  assign servo_on = ctrl[PNS_CTRL_SERVO_BIT];
  // a wide width lets completion come while still moving
  assign in_width = {{(32-DIST_W){1'b0}}, remaining_distance} <= pos_width;
  // a start held high must not launch again
  assign start_rise = start_request && !start_q;

  // pattern width mask for both position buses
  always_comb
  begin
    pmask = '0;
    for (int i = 0; i < POS_W; i++)
    begin
      if (i < 6)
        pmask[i] = 1'b1;
      else if (i < 8)
        pmask[i] = (pattern == 2'h2) || (pattern == 2'h3);
      else
        pmask[i] = (pattern == 2'h3);
    end
  end

  always_comb
  begin
    st_d = st_q;
    home_d = home_q;
    positioning_complete_d = positioning_complete_q;
    move_d = move_q;
    tgt_d = tgt_q;
    cpos_d = cpos_q;
    last_d = last_q;
    launch_d = 1'b0;
    hl_d = 1'b0;
    if (!servo_on)
    begin
      st_d = PNS_IDLE;
      positioning_complete_d = 1'b0;
      move_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        PNS_IDLE, PNS_DONE:
        begin
          if (st_q == PNS_DONE && inp_mode)
            positioning_complete_d = in_width;
          // motion flag ends once the core has nothing pending
          if (!motion_pending)
            move_d = 1'b0;
          if (start_rise)
          begin
            tgt_d = cmd_position_number & pmask;
            positioning_complete_d = 1'b0;
            cpos_d = '0;
            if (!home_q)
            begin
              st_d = PNS_HOME;
              hl_d = 1'b1;
              move_d = 1'b1;
            end
            else
            begin
              st_d = PNS_MOVE;
              launch_d = 1'b1;
              move_d = ((cmd_position_number & pmask) != last_q);
            end
          end
        end
        PNS_HOME:
        begin
          if (home_finished)
          begin
            home_d = 1'b1;
            st_d = PNS_MOVE;
            launch_d = 1'b1;
          end
        end
        PNS_MOVE:
        begin
          if (start_rise)
          begin
            tgt_d = cmd_position_number & pmask;
            launch_d = 1'b1;
            move_d = 1'b1;
          end
          else if (!motion_pending && !launch_q)
            move_d = 1'b0;
          if (in_width && !launch_q && !start_request)
          begin
            st_d = PNS_DONE;
            positioning_complete_d = 1'b1;
            cpos_d = tgt_q;
            last_d = tgt_q;
          end
        end
        default:
          st_d = PNS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= PNS_IDLE;
      start_q <= 1'b0;
      home_q <= 1'b0;
      positioning_complete_q <= 1'b0;
      move_q <= 1'b0;
      launch_q <= 1'b0;
      hl_q <= 1'b0;
      tgt_q <= '0;
      cpos_q <= '0;
      last_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      start_q <= start_request;
      home_q <= home_d;
      positioning_complete_q <= positioning_complete_d;
      move_q <= move_d;
      launch_q <= launch_d;
      hl_q <= hl_d;
      tgt_q <= tgt_d;
      cpos_q <= cpos_d;
      last_q <= last_d;
    end
  end

  assign out_pos = move_q ? '0 : (cpos_q & pmask);
  assign completed_position_number = out_pos;
  assign positioning_complete = positioning_complete_q;
  assign motion_active = move_q && (pattern[1] == 1'b0);
  assign home_return_done = home_q;
  assign move_launch = launch_q;
  assign move_target = tgt_q;
  assign home_launch = hl_q;
  assign stat_w = {27'h000_0000, st_q == PNS_HOME, home_q, move_q, positioning_complete_q, st_q == PNS_MOVE};
  assign cpos_w = {{(32-POS_W){1'b0}}, out_pos};

  // register slave: control, width, status and completed number
  pns_axil_regs pns_axil_regs_inst (
    .clk(clk),
    .rst(rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .stat_in(stat_w),
    .cpos_in(cpos_w),
    .ctrl(ctrl),
    .pos_width(pos_width)
  );

  // handshake and output checks
  chk_drop_on_start: assert property (@(posedge clk) disable iff (rst)
    servo_on && start_rise && st_q != PNS_MOVE |=> !positioning_complete)
    else $error("complete not dropped at start");
  chk_hold_while_start: assert property (@(posedge clk) disable iff (rst)
    start_request && !$past(positioning_complete) && st_q == PNS_MOVE |=> !positioning_complete)
    else $error("complete rose while start held");
  chk_hold_number: assert property (@(posedge clk) disable iff (rst)
    start_request && st_q == PNS_MOVE |=> completed_position_number == '0)
    else $error("completed number shown while start held");
  chk_zero_moving: assert property (@(posedge clk) disable iff (rst)
    motion_active |-> completed_position_number == '0)
    else $error("completed number nonzero while moving");
  chk_done_number: assert property (@(posedge clk) disable iff (rst)
    $rose(positioning_complete) && !inp_mode |-> cpos_q == tgt_q)
    else $error("wrong completed number");
  chk_finish_complete: assert property (@(posedge clk) disable iff (rst)
    servo_on && st_q == PNS_MOVE && in_width && !launch_q && !start_request |=> positioning_complete)
    else $error("complete not raised inside width");
  chk_launch_start: assert property (@(posedge clk) disable iff (rst)
    servo_on && home_q && start_rise && st_q == PNS_IDLE |=> move_launch)
    else $error("no launch after start");
  chk_motion_start: assert property (@(posedge clk) disable iff (rst)
    servo_on && start_rise && st_q != PNS_HOME && (cmd_position_number & pmask) != last_q |=> move_q)
    else $error("motion flag not raised at start");
  chk_motion_drop: assert property (@(posedge clk) disable iff (rst)
    servo_on && st_q != PNS_HOME && !launch_q && !motion_pending && !start_rise |=> !move_q)
    else $error("motion flag held with nothing pending");
  chk_same_no_motion: assert property (@(posedge clk) disable iff (rst)
    servo_on && home_q && start_rise && st_q == PNS_DONE && (cmd_position_number & pmask) == last_q
    |=> !move_q && !positioning_complete)
    else $error("same position raised motion");
  chk_latch_hold: assert property (@(posedge clk) disable iff (rst)
    positioning_complete && !inp_mode && servo_on && !start_rise && st_q == PNS_DONE |=> positioning_complete)
    else $error("latched complete cleared");
  chk_servo_off: assert property (@(posedge clk) disable iff (rst)
    !servo_on |=> !positioning_complete && !move_q)
    else $error("complete kept with servo off");
  chk_inp_clear: assert property (@(posedge clk) disable iff (rst)
    st_q == PNS_DONE && inp_mode && servo_on && !in_width && !start_rise |=> !positioning_complete)
    else $error("in-position flag not cleared");
  chk_home_first: assert property (@(posedge clk) disable iff (rst)
    servo_on && !home_q && start_rise && st_q == PNS_IDLE |=> home_launch && !move_launch)
    else $error("home return skipped");
  chk_home_pulse: assert property (@(posedge clk) disable iff (rst)
    home_launch |=> !home_launch)
    else $error("home launch longer than one cycle");
  chk_home_to_move: assert property (@(posedge clk) disable iff (rst)
    servo_on && st_q == PNS_HOME && home_finished |=> move_launch && home_return_done)
    else $error("no move after home return");
  chk_no_relaunch: assert property (@(posedge clk) disable iff (rst)
    start_request && start_q |=> !move_launch || $past(st_q) == PNS_HOME)
    else $error("held start relaunched");
  chk_motion_pattern: assert property (@(posedge clk) disable iff (rst)
    pattern[1] |-> !motion_active)
    else $error("motion flag in pattern 2 or 3");
  chk_number_masked: assert property (@(posedge clk) disable iff (rst)
    (completed_position_number & ~pmask) == '0)
    else $error("completed number wider than pattern");

  // main scenarios
  cov_move_done: cover property (@(posedge clk) disable iff (rst) $rose(positioning_complete));
  cov_home: cover property (@(posedge clk) disable iff (rst) home_launch);
  cov_same_pos: cover property (@(posedge clk) disable iff (rst) move_launch && !motion_active);
  cov_early_complete: cover property (@(posedge clk) disable iff (rst) positioning_complete && motion_active);
  cov_inp_clear: cover property (@(posedge clk) disable iff (rst) inp_mode && $fell(positioning_complete));
endmodule : pns_top

// ===== verif/pns_motion_model.sv
// motion core model driving distance, pending and home finish
`timescale 1ns/100ps
module pns_motion_model
  import pns_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic move_launch,
  input wire logic [8:0] move_target,
  input wire logic home_launch,
  input wire logic slow,
  input wire logic drift,
  output logic home_finished,
  output logic [23:0] remaining_distance,
  output logic motion_pending
);
  logic [23:0] dist_q;
  logic [8:0] last_q;
  logic [3:0] home_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dist_q <= 24'h00_0000;
      last_q <= 9'h1ff;
      home_q <= 4'h0;
      home_finished <= 1'b0;
    end
    else
    begin
      home_finished <= (home_q == 4'h1);
      if (home_launch)
        home_q <= 4'ha;
      else if (home_q != 4'h0)
        home_q <= home_q - 4'h1;
      if (move_launch)
      begin
        // same target: nothing left to travel
        dist_q <= (move_target == last_q) ? 24'h00_0000 : (slow ? 24'h00_00c8 : 24'h00_0028);
        last_q <= move_target;
      end
      else if (dist_q != 24'h00_0000)
        dist_q <= dist_q - 24'h00_0001;
    end
  end
  // drift pushes position outside the width while stopped
  assign remaining_distance = drift ? 24'h00_0100 : dist_q;
  assign motion_pending = (dist_q != 24'h00_0000);
endmodule : pns_motion_model

// ===== verif/pns_bench.sv
// bench for the position number start handshake
`timescale 1ns/100ps
module position_number_start_handshake_bench
  import pns_pkg::*;
;
  logic clk = 0, rst = 1, start_request = 0, slow = 0, drift = 0;
  logic [8:0] cmd_position_number = 9'h000, completed_position_number, move_target, last_pos;
  logic positioning_complete, motion_active, home_return_done, move_launch, home_launch, home_finished;
  logic [23:0] remaining_distance;
  logic motion_pending, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, done_q, mp_q;
  logic [15:0] s_awaddr = 16'h0000, s_araddr = 16'h0000;
  logic [31:0] s_wdata = 32'h0000_0000, s_rdata;
  logic [3:0] s_wstrb = 4'hf;
  logic [1:0] s_bresp, s_rresp, pat;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [8:0] cq[$];
  int fail_count = 0, compares = 0, cyc = 0;
  bit homed = 0;
  always #5 clk = ~clk;
  pns_top pns_top_inst (.clk(clk), .rst(rst), .cmd_position_number(cmd_position_number),
    .start_request(start_request), .completed_position_number(completed_position_number),
    .positioning_complete(positioning_complete), .motion_active(motion_active),
    .home_return_done(home_return_done), .move_launch(move_launch), .move_target(move_target),
    .home_launch(home_launch), .home_finished(home_finished), .remaining_distance(remaining_distance),
    .motion_pending(motion_pending), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  pns_motion_model pns_motion_model_inst (.clk(clk), .rst(rst), .move_launch(move_launch),
    .move_target(move_target), .home_launch(home_launch), .slow(slow), .drift(drift),
    .home_finished(home_finished), .remaining_distance(remaining_distance), .motion_pending(motion_pending));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      tally_and_finish();
    end
    else
    begin
      if (s_rvalid && s_rready)
        chk({s_rresp, s_rdata}, rq.pop_front());
      if (s_bvalid && s_bready)
        chk(s_bresp, bq.pop_front());
    end
  end
  // finished move: complete up, no motion and core idle a cycle
  always @(negedge clk)
  begin
    if (positioning_complete && !motion_active && !mp_q && !done_q && cq.size() > 0)
      chk(completed_position_number, cq.pop_front());
    done_q <= positioning_complete && !motion_active && !mp_q;
    mp_q <= motion_pending;
  end
  task axw(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    bq.push_back(r);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge clk);
      if (s_awvalid && s_awready)
      begin
        aw = 1;
        s_awvalid <= 0;
      end
      if (s_wvalid && s_wready)
      begin
        w = 1;
        s_wvalid <= 0;
      end
    end
    while (!s_bvalid)
      @(posedge clk);
    s_bready <= 0;
  endtask : axw
  task axr(input logic [15:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    do @(posedge clk); while (!s_arready);
    s_arvalid <= 0;
    while (!s_rvalid)
      @(posedge clk);
    s_rready <= 0;
  endtask : axr
  task do_move(input logic [8:0] pos, input bit hold);
    logic [8:0] m;
    bit mv;
    m = pos & ((pat < 2) ? 9'h03f : (pat == 2) ? 9'h0ff : 9'h1ff);
    mv = (m != last_pos) && (pat < 2);
    @(posedge clk);
    cmd_position_number <= pos;
    repeat (3) @(posedge clk);
    start_request <= 1;
    repeat (3) @(posedge clk);
    chk(positioning_complete, 0);
    chk(move_target, m);
    if (homed)
      chk(motion_active, mv);
    if (homed && mv)
      chk(completed_position_number, 0);
    if (hold)
    begin
      @(posedge clk iff !motion_active);
      repeat (5) @(posedge clk);
      chk(positioning_complete, 0);
    end
    cq.push_back(m);
    start_request <= 0;
    if (hold)
    begin
      repeat (2) @(posedge clk);
      chk(positioning_complete, 1);
    end
    @(posedge clk iff positioning_complete);
    if (homed && mv && !hold)
      chk(motion_active, 1);
    @(posedge clk iff (positioning_complete && !motion_active && !motion_pending));
    repeat (2) @(posedge clk);
    last_pos = m;
    homed = 1;
  endtask : do_move
  initial
  begin
    void'($urandom(41));
    pat = 2'h0;
    last_pos = 9'h1ff;
    repeat (12) @(posedge clk);
    rst <= 0;
    axr(PNS_ADDR_CTRL, {PNS_RESP_OKAY, 32'h0000_0000});
    axr(PNS_ADDR_WIDTH, {PNS_RESP_OKAY, PNS_WIDTH_RESET});
    axr(16'h0020, {PNS_RESP_SLVERR, 32'h0000_0000});
    axw(16'h0020, 32'h0000_00ff, PNS_RESP_SLVERR);
    axw(PNS_ADDR_STAT, 32'hffff_ffff, PNS_RESP_OKAY);
    axr(PNS_ADDR_STAT, {PNS_RESP_OKAY, 32'h0000_0000});
    axw(PNS_ADDR_CTRL, 32'h0000_0008, PNS_RESP_OKAY);
    $display("register test done");
    chk(home_return_done, 0);
    do_move(9'h005, 0);
    chk(home_return_done, 1);
    axr(PNS_ADDR_CPOS, {PNS_RESP_OKAY, 32'h0000_0005});
    do_move(9'h009, 1);
    do_move(9'h009, 0);
    slow <= 1;
    do_move(9'h003, 0);
    slow <= 0;
    $display("sequence test done");
    for (int p = 0; p < 4; p++)
    begin
      pat = p[1:0];
      axw(PNS_ADDR_CTRL, 32'h0000_0008 | p, PNS_RESP_OKAY);
      do_move(9'($urandom()), 0);
    end
    $display("pattern test done");
    drift <= 1;
    repeat (5) @(posedge clk);
    chk(positioning_complete, 1);
    drift <= 0;
    axw(PNS_ADDR_CTRL, 32'h0000_000f, PNS_RESP_OKAY);
    drift <= 1;
    repeat (4) @(posedge clk);
    chk(positioning_complete, 0);
    drift <= 0;
    repeat (4) @(posedge clk);
    chk(positioning_complete, 1);
    axw(PNS_ADDR_CTRL, 32'h0000_0000, PNS_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(positioning_complete, 0);
    $display("latch test done");
    tally_and_finish();
  end
endmodule : position_number_start_handshake_bench
